// ### bench/sdram_ctrl_model.sv
/* Memory controller model on the command pins of the DRAM front end.
   Assumes it shares clk_i with the device; the bench calls its tasks. */
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_model
	import sdram_front_pkg::*;
(
	input  wire logic   clk_i,
	output logic        cke_o,
	output logic        cs_n_o,
	output logic [2:0]  cmd_o,
	output logic [1:0]  bank_o,
	output logic [12:0] addr_o,
	output logic [1:0]  mask_o,
	output logic [15:0] data_o
);
	localparam int INIT_WAIT = 8000; // 200 us at 40 MHz

	// ==========================================================
	// power-up levels
	initial begin
		cke_o  = 1'b1;
		cs_n_o = 1'b0;
		cmd_o  = CMD_NOP;
		bank_o = 2'h0;
		addr_o = 13'h0000;
		mask_o = 2'h3;
		data_o = 16'h0000;
	end

	// ==========================================================
	// one pin cycle, launched just after an edge
	task automatic put(input logic n, input logic [2:0] c, input logic [1:0] b,
		input logic [12:0] a, input logic [1:0] m, input logic [15:0] d);
		@(posedge clk_i);
		cs_n_o <= n;
		cmd_o  <= c;
		bank_o <= b;
		addr_o <= a;
		mask_o <= m;
		data_o <= d;
	endtask

	task automatic set_cke(input logic v);
		cke_o <= v;
	endtask

	// unused data toggles, so a stale word never looks valid
	task automatic idle(input int n, input logic [1:0] m);
		repeat (n) put(1'b0, CMD_NOP, 2'h0, 13'h0000, m, ~data_o);
	endtask

	// ==========================================================
	// initialization and row handling
	task automatic init();
		idle(INIT_WAIT, 2'h3);
		put(1'b0, CMD_PRECHARGE, 2'h0, 13'h0400, 2'h3, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			put(1'b0, CMD_REFRESH, 2'h0, 13'h0000, 2'h0, 16'h0000);
			idle(ROW_CYCLE_TIME, 2'h0);
		end
	endtask

	task automatic mode_set(input logic [12:0] v);
		put(1'b0, CMD_MODE_SET, 2'h0, v, 2'h0, 16'h0000);
		idle(MODE_SET_RECOVERY, 2'h0);
	endtask

	// a full row cycle covers the access and bank-to-bank delays as well
	task automatic act(input logic [1:0] b, input logic [12:0] r);
		put(1'b0, CMD_ACTIVATE, b, r, 2'h0, 16'h0000);
		idle(ROW_CYCLE_TIME, 2'h0);
	endtask
endmodule
`default_nettype wire

// ### bench/sdram_front_properties.sv
/* Concurrent checks on the ports of the DRAM command front end.
   Assumes one clock and the synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module sdram_front_properties
	import sdram_front_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        cke_i,
	input wire logic        cs_n_i,
	input wire logic        ras_n_i,
	input wire logic        cas_n_i,
	input wire logic        we_n_i,
	input wire logic [12:0] addr_i,
	input wire logic [1:0]  bank_select_i,
	input wire logic        lower_byte_mask_i,
	input wire logic        upper_byte_mask_i,
	input wire logic [15:0] rd_data_i,
	input wire logic        rd_data_valid_i,
	input wire logic [15:0] data_lines_o,
	input wire logic [1:0]  data_lines_oe_o,
	input wire logic        activate_o,
	input wire logic [1:0]  act_bank_o,
	input wire logic [12:0] act_row_o,
	input wire logic        precharge_o,
	input wire logic        cmd_error_o,
	input wire logic        rd_req_o,
	input wire logic [8:0]  rd_col_o,
	input wire logic [1:0]  power_state_o,
	input wire logic [12:0] mode_reg_o,
	input wire logic        mode_valid_o,
	input wire logic [3:0]  bank_open_o
);
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// ==========================================================
	// taken command: power state lags, so cke must have stayed high too
	sequence take(logic [2:0] code);
		!cs_n_i && cke_i && $past(cke_i) && power_state_o == PWR_ACTIVE
			&& {ras_n_i, cas_n_i, we_n_i} == code;
	endsequence

	chk_act_fields: assert property (
		take(CMD_ACTIVATE) |=> activate_o && act_bank_o == $past(bank_select_i) && act_row_o == $past(addr_i))
		else $error("activate outputs wrong");
	chk_cs_ignore: assert property (
		cs_n_i |=> !activate_o && !cmd_error_o)
		else $error("command taken without chip select");
	chk_mode_write: assert property (
		take(CMD_MODE_SET) |=> (mode_valid_o && mode_reg_o == $past(addr_i)) != cmd_error_o)
		else $error("mode set handled wrongly");
	chk_mode_undef: assert property (
		!mode_valid_o && {ras_n_i, cas_n_i, we_n_i} != CMD_MODE_SET |=> !mode_valid_o)
		else $error("mode valid without mode set");
	chk_read_beat: assert property (
		take(CMD_READ) |=> rd_req_o && rd_col_o == $past(addr_i[8:0]))
		else $error("read beat wrong");
	chk_read_mask: assert property (
		rd_data_valid_i |=> data_lines_oe_o == ~$past({upper_byte_mask_i, lower_byte_mask_i}, 3)
			&& data_lines_o == $past(rd_data_i))
		else $error("read drive enable wrong");
	chk_pre_all: assert property (
		take(CMD_PRECHARGE) ##0 addr_i[PRECHARGE_SELECT_BIT] |=> precharge_o ##1 bank_open_o == 4'h0)
		else $error("precharge all left a bank open");
	chk_low_power: assert property (
		power_state_o == PWR_ACTIVE && $past(cke_i) && !cke_i |-> ##2 power_state_o != PWR_ACTIVE)
		else $error("clock enable low ignored");
endmodule

bind sdram_command_init_activate sdram_front_properties chk_u (
	.clk_i, .reset_i, .cke_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i, .addr_i, .bank_select_i,
	.lower_byte_mask_i, .upper_byte_mask_i, .rd_data_i, .rd_data_valid_i, .data_lines_o,
	.data_lines_oe_o, .activate_o, .act_bank_o, .act_row_o, .precharge_o, .cmd_error_o,
	.rd_req_o, .rd_col_o, .power_state_o, .mode_reg_o, .mode_valid_o, .bank_open_o
);
`default_nettype wire

// ### bench/testbench.sv
/* Self-checking bench for the DRAM command front end.
   Assumes the controller model drives the pins; the bench plays the array core. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sdram_front_pkg::*;
	localparam int LIMIT = 12000;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        rd_valid = 1'b0;
	logic        wr_ready = 1'b0;
	logic [15:0] rd_data = 16'h0000;
	logic        cke, cs_n, act, pre, refr, err, rd_req, wr_valid, q_ready, mode_ok;
	logic [2:0]  cmd;
	logic [1:0]  bank, mask, oe, be, abank, rbank, wbank, pstate;
	logic [12:0] addr, arow, mode;
	logic [15:0] din, dout, wdata;
	logic [8:0]  rcol, wcol;
	logic [3:0]  open_b;
	logic [26:0] exp_w [3];
	int          num_errors = 0;
	int          compares = 0;
	int          cycles = 0;
	int          n;

	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	sdram_ctrl_model p_u (.clk_i, .cke_o(cke), .cs_n_o(cs_n), .cmd_o(cmd), .bank_o(bank),
		.addr_o(addr), .mask_o(mask), .data_o(din));
	sdram_command_init_activate dut_u (.clk_i, .reset_i, .cke_i(cke), .cs_n_i(cs_n),
		.ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .addr_i(addr), .bank_select_i(bank),
		.lower_byte_mask_i(mask[0]), .upper_byte_mask_i(mask[1]), .data_lines_i(din),
		.data_lines_o(dout), .data_lines_oe_o(oe), .activate_o(act), .act_bank_o(abank),
		.act_row_o(arow), .precharge_o(pre), .auto_refresh_cmd_o(refr), .cmd_error_o(err),
		.rd_req_o(rd_req), .rd_bank_o(rbank), .rd_col_o(rcol), .rd_data_i(rd_data),
		.rd_data_valid_i(rd_valid), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
		.wr_bank_o(wbank), .wr_col_o(wcol), .wr_byte_en_o(be), .wr_data_o(wdata),
		.wr_queue_ready_o(q_ready), .power_state_o(pstate), .mode_reg_o(mode),
		.mode_valid_o(mode_ok), .bank_open_o(open_b));

	// ==========================================================
	// checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want) begin
			num_errors++;
			$display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, want);
		end
	endtask

	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// idle k edges, then let the last edge's updates land
	task automatic step(input int k);
		p_u.idle(k, 2'h0);
		#1;
	endtask

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			num_errors++;
			final_report();
		end
	end

	// ==========================================================
	// tests
	initial begin
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		#1;
		check({open_b, wr_valid, q_ready, mode_ok}, 7'h02);
		$display("test reset done");
		p_u.init();
		#1;
		check(mode_ok, 1'b0);
		p_u.mode_set(13'h0032);
		#1;
		check({mode_ok, mode}, {1'b1, 13'h0032});
		$display("test init done");
		p_u.act(2'h0, 13'h0005);
		p_u.put(1'b0, CMD_ACTIVATE, 2'h2, 13'h1ABC, 2'h0, 16'h0000);
		step(1);
		check({act, abank, arow}, {1'b1, 2'h2, 13'h1ABC});
		step(1);
		check(open_b, 4'h5);
		p_u.put(1'b1, CMD_ACTIVATE, 2'h3, 13'h0077, 2'h0, 16'h0000);
		step(2);
		check({act, err, open_b}, 6'h05);
		$display("test activate done");
		// chip select dropped mid-burst must not stop the beats
		p_u.put(1'b0, CMD_READ, 2'h2, 13'h01F5, 2'h0, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			p_u.put(1'b1, CMD_NOP, 2'h0, 13'h0000, 2'h0, 16'h0000);
			#1;
			check({rd_req, rbank, rcol}, {1'b1, 2'h2, 9'h1F5 + 9'(i)});
		end
		step(1);
		check(rd_req, 1'b0);
		p_u.put(1'b0, CMD_NOP, 2'h0, 13'h0000, 2'h1, 16'h0000);
		p_u.idle(2, 2'h0);
		rd_valid <= 1'b1;
		rd_data <= 16'hBEEF;
		p_u.idle(1, 2'h0);
		rd_valid <= 1'b0;
		#1;
		check({oe, dout}, {2'h2, 16'hBEEF});
		$display("test read done");
		p_u.act(2'h1, 13'h0123);
		exp_w = '{{9'h040, 2'h3, 16'h1111}, {9'h041, 2'h2, 16'h2222}, {9'h042, 2'h1, 16'h3333}};
		for (int i = 0; i < 4; i++) begin
			p_u.put(1'b0, i == 0 ? CMD_WRITE : CMD_NOP, 2'h1, 13'h0040, 2'(i), 16'h1111 * 16'(i + 1));
		end
		for (int i = 0; i < 32; i++) begin
			p_u.put(1'b0, i % 4 == 0 ? CMD_WRITE : CMD_NOP, 2'h1, 13'h0100, 2'h0, 16'(i));
		end
		step(2);
		check({q_ready, wr_valid}, 2'h1);
		@(posedge clk_i);
		wr_ready <= 1'b1;
		n = 0;
		repeat (40) begin
			@(negedge clk_i);
			if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
				if (n < 3) check({wbank, wcol, be, wdata}, {2'h1, exp_w[n]});
				n++;
			end
		end
		check(n, 32);
		check(wr_valid, 1'b0);
		$display("test write done");
		p_u.put(1'b0, CMD_MODE_SET, 2'h0, 13'h0021, 2'h0, 16'h0000);
		step(1);
		check({err, mode}, {1'b1, 13'h0032});
		p_u.put(1'b0, CMD_READ, 2'h3, 13'h0000, 2'h0, 16'h0000);
		step(1);
		check(err, 1'b1);
		p_u.put(1'b0, CMD_BURST_STOP, 2'h0, 13'h0000, 2'h0, 16'h0000);
		step(1);
		check(rd_req, 1'b0);
		$display("test errors done");
		p_u.put(1'b0, CMD_READ, 2'h1, 13'h0400, 2'h0, 16'h0000);
		n = 0;
		repeat (6) begin
			step(1);
			n += int'(pre === 1'b1);
		end
		check(n, 1);
		check(open_b, 4'h5);
		p_u.put(1'b0, CMD_PRECHARGE, 2'h2, 13'h0000, 2'h0, 16'h0000);
		step(2);
		check(open_b, 4'h1);
		p_u.put(1'b0, CMD_PRECHARGE, 2'h2, 13'h0400, 2'h0, 16'h0000);
		step(2);
		check(open_b, 4'h0);
		$display("test precharge done");
		p_u.set_cke(1'b0);
		step(3);
		check(pstate, PWR_DOWN);
		p_u.set_cke(1'b1);
		step(4);
		check(pstate, PWR_ACTIVE);
		p_u.put(1'b0, CMD_REFRESH, 2'h0, 13'h0000, 2'h0, 16'h0000);
		p_u.set_cke(1'b0);
		step(3);
		check({refr, pstate}, {1'b0, PWR_SELF_REFRESH});
		p_u.set_cke(1'b1);
		step(4);
		check(pstate, PWR_ACTIVE);
		$display("test power done");
		final_report();
	end
endmodule
`default_nettype wire

// ### verilog/bank_tracker.sv
/*
 * Open/closed flag per bank, set by activate and cleared by precharge
 * (single or all) or by an auto-precharge closing at burst end.
 * Assumes the strobes are already gated by chip select and clock enable.
 */
`default_nettype none
`timescale 1ns/1ps
module bank_tracker
	import sdram_front_pkg::*;
#(
	parameter int NUM_BANKS = sdram_front_pkg::BANKS
) (
	input  wire logic                              clk_i,
	input  wire logic                              reset_i,
	input  wire logic                              act_i,
	input  wire logic [sdram_front_pkg::BANK_W-1:0] act_bank_i,
	input  wire logic                              pre_i,
	input  wire logic                              pre_all_i,
	input  wire logic [sdram_front_pkg::BANK_W-1:0] pre_bank_i,
	input  wire logic                              close_i,
	input  wire logic [sdram_front_pkg::BANK_W-1:0] close_bank_i,
	output logic      [NUM_BANKS-1:0]              open_o
);
	// ==========================================================
	// one flag per bank; closing wins since the controller never
	// opens and closes the same bank at one edge
	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			logic hit_pre;
			logic hit_close;
			logic hit_act;
			assign hit_pre   = pre_i & (pre_all_i | (pre_bank_i == BANK_W'(b)));
			assign hit_close = close_i & (close_bank_i == BANK_W'(b));
			assign hit_act   = act_i & (act_bank_i == BANK_W'(b));
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					open_o[b] <= 1'b0;
				end else if (hit_pre | hit_close) begin
					open_o[b] <= 1'b0;
				end else if (hit_act) begin
					open_o[b] <= 1'b1;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ### verilog/sdram_command_init_activate.sv
/*
 * Command front end of a four-bank 16-bit synchronous DRAM: decodes pin
 * commands, tracks open banks, holds the mode register, handles byte masks,
 * low-power entry by clock enable and queues write beats for the core.
 * Assumes the controller runs on clk_i, so pins need no synchroniser, and
 * that the array core answers read requests on rd_data_valid_i.
 */
// Behaviour
// - row on address 0-12, column on 0-8
// - bit 10 at precharge picks all or one
// - bank select picks bank for activate/access
// - chip select high ignores commands, work continues
// - strobes together decode the command
// - inputs sampled only on rising clock edge
// - read mask high floats byte two cycles later
// - write mask high blocks byte same cycle
// - clock enable low enters a low-power state
// - mode register undefined until first programmed
// - mode set is all four strobes low
// - row high, column low: read or write
// - bit 10 with access selects auto-precharge
`default_nettype none
`timescale 1ns/1ps
module sdram_command_init_activate
	import sdram_front_pkg::*;
#(
	parameter int BURST_LEN   = sdram_front_pkg::BURST_LEN_DEF,
	parameter int QUEUE_DEPTH = sdram_front_pkg::WQ_DEPTH
) (
	input  wire logic                               clk_i,
	input  wire logic                               reset_i,
	input  wire logic                               cke_i,
	input  wire logic                               cs_n_i,
	input  wire logic                               ras_n_i,
	input  wire logic                               cas_n_i,
	input  wire logic                               we_n_i,
	input  wire logic [sdram_front_pkg::ROW_W-1:0]  addr_i,
	input  wire logic [sdram_front_pkg::BANK_W-1:0] bank_select_i,
	input  wire logic                               lower_byte_mask_i,
	input  wire logic                               upper_byte_mask_i,
	input  wire logic [sdram_front_pkg::DATA_W-1:0] data_lines_i,
	output logic      [sdram_front_pkg::DATA_W-1:0] data_lines_o,
	output logic      [sdram_front_pkg::BYTES-1:0]  data_lines_oe_o,
	output logic                                    activate_o,
	output logic      [sdram_front_pkg::BANK_W-1:0] act_bank_o,
	output logic      [sdram_front_pkg::ROW_W-1:0]  act_row_o,
	output logic                                    precharge_o,
	output logic                                    auto_refresh_cmd_o,
	output logic                                    cmd_error_o,
	output logic                                    rd_req_o,
	output logic      [sdram_front_pkg::BANK_W-1:0] rd_bank_o,
	output logic      [sdram_front_pkg::COL_W-1:0]  rd_col_o,
	input  wire logic [sdram_front_pkg::DATA_W-1:0] rd_data_i,
	input  wire logic                               rd_data_valid_i,
	output logic                                    wr_valid_o,
	input  wire logic                               wr_ready_i,
	output logic      [sdram_front_pkg::BANK_W-1:0] wr_bank_o,
	output logic      [sdram_front_pkg::COL_W-1:0]  wr_col_o,
	output logic      [sdram_front_pkg::BYTES-1:0]  wr_byte_en_o,
	output logic      [sdram_front_pkg::DATA_W-1:0] wr_data_o,
	output logic                                    wr_queue_ready_o,
	output logic      [1:0]                         power_state_o,
	output logic      [sdram_front_pkg::ROW_W-1:0]  mode_reg_o,
	output logic                                    mode_valid_o,
	output logic      [sdram_front_pkg::BANKS-1:0]  bank_open_o
);
	import sdram_front_pkg::*;

	localparam logic [BURST_CNT_W-1:0] BURST_RELOAD = BURST_CNT_W'(BURST_LEN - 1);

	// ==========================================================
	// command decode
	cmd_e                  cmd;
	pwr_e                  pwr_reg;
	logic                  decoder_on;
	logic                  is_act;
	logic                  is_pre;
	logic                  is_ref;
	logic                  is_mrs;
	logic                  is_rd;
	logic                  is_wr;
	logic                  is_bst;
	logic                  advance;
	logic [BYTES-1:0]      mask_now;
	logic [BANKS-1:0]      open_flags;

	// every pin is a plain flop input on clk_i's rising edge
	assign cmd        = cmd_e'({ras_n_i, cas_n_i, we_n_i});
	assign decoder_on = ~cs_n_i & cke_i & (pwr_reg == PWR_ACTIVE);
	assign is_act     = decoder_on & (cmd == CMD_ACTIVATE);
	assign is_pre     = decoder_on & (cmd == CMD_PRECHARGE);
	assign is_ref     = decoder_on & (cmd == CMD_REFRESH);
	assign is_mrs     = decoder_on & (cmd == CMD_MODE_SET);
	assign is_rd      = decoder_on & (cmd == CMD_READ);
	assign is_wr      = decoder_on & (cmd == CMD_WRITE);
	assign is_bst     = decoder_on & (cmd == CMD_BURST_STOP);
	assign advance    = cke_i & (pwr_reg == PWR_ACTIVE);
	assign mask_now   = {upper_byte_mask_i, lower_byte_mask_i};

	// ==========================================================
	// burst state
	logic [BURST_CNT_W-1:0] burst_cnt_reg;
	logic                   burst_write_reg;
	logic                   burst_ap_reg;
	logic [BANK_W-1:0]      burst_bank_reg;
	logic [COL_W-1:0]       burst_col_reg;
	logic                   beat_extra;
	logic                   ap_close;

	// beats after the command beat; frozen while the clock is suspended
	assign beat_extra = advance & (burst_cnt_reg != BURST_NONE) & ~is_rd & ~is_wr & ~is_bst;
	assign ap_close   = beat_extra & burst_ap_reg & (burst_cnt_reg == BURST_LAST);

	// a new access overrides the remainder of a running burst
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			burst_cnt_reg   <= BURST_NONE;
			burst_write_reg <= 1'b0;
			burst_ap_reg    <= 1'b0;
			burst_bank_reg  <= '0;
			burst_col_reg   <= '0;
		end else if (is_rd | is_wr) begin
			burst_cnt_reg   <= BURST_RELOAD;
			burst_write_reg <= is_wr;
			burst_ap_reg    <= addr_i[PRECHARGE_SELECT_BIT];
			burst_bank_reg  <= bank_select_i;
			burst_col_reg   <= addr_i[COL_W-1:0] + COL_STEP;
		end else if (is_bst | is_pre) begin
			burst_cnt_reg <= BURST_NONE;
			burst_ap_reg  <= 1'b0;
		end else if (beat_extra) begin
			burst_cnt_reg <= burst_cnt_reg - BURST_LAST;
			burst_col_reg <= burst_col_reg + COL_STEP;
		end
	end

	// ==========================================================
	// power state
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pwr_reg <= PWR_ACTIVE;
		end else begin
			case (pwr_reg)
				PWR_ACTIVE: begin
					if (~cke_i) begin
						if (~cs_n_i & (cmd == CMD_REFRESH)) begin
							pwr_reg <= PWR_SELF_REFRESH;
						end else if (burst_cnt_reg != BURST_NONE) begin
							pwr_reg <= PWR_SUSPEND;
						end else begin
							pwr_reg <= PWR_DOWN;
						end
					end
				end
				PWR_DOWN, PWR_SUSPEND, PWR_SELF_REFRESH: begin
					if (cke_i) begin
						pwr_reg <= PWR_ACTIVE;
					end
				end
				default: begin
					pwr_reg <= PWR_ACTIVE;
				end
			endcase
		end
	end

	// ==========================================================
	// bank flags
	bank_tracker #(
		.NUM_BANKS    (BANKS)
	) u_banks (
		.clk_i        (clk_i),
		.reset_i      (reset_i),
		.act_i        (is_act),
		.act_bank_i   (bank_select_i),
		.pre_i        (is_pre),
		.pre_all_i    (addr_i[PRECHARGE_SELECT_BIT]),
		.pre_bank_i   (bank_select_i),
		.close_i      (ap_close),
		.close_bank_i (burst_bank_reg),
		.open_o       (open_flags)
	);

	// ==========================================================
	// mode register: valid only once programmed on idle banks
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mode_reg_o   <= MODE_RESET;
			mode_valid_o <= 1'b0;
		end else if (is_mrs & ~(|open_flags)) begin
			mode_reg_o   <= addr_i;
			mode_valid_o <= 1'b1;
		end
	end

	// ==========================================================
	// command reporting and misuse flag
	logic access_closed;
	logic act_on_open;

	assign access_closed = (is_rd | is_wr) & ~open_flags[bank_select_i];
	assign act_on_open   = is_act & open_flags[bank_select_i];

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			activate_o         <= 1'b0;
			act_bank_o         <= '0;
			act_row_o          <= '0;
			precharge_o        <= 1'b0;
			auto_refresh_cmd_o <= 1'b0;
			cmd_error_o        <= 1'b0;
			bank_open_o        <= '0;
			power_state_o      <= PWR_ACTIVE;
		end else begin
			activate_o         <= is_act;
			precharge_o        <= is_pre | ap_close;
			auto_refresh_cmd_o <= is_ref;
			// misuse is reported; it blocks only a mode set while a bank is open
			cmd_error_o        <= access_closed | act_on_open | (is_mrs & (|open_flags));
			bank_open_o        <= open_flags;
			power_state_o      <= pwr_reg;
			if (is_act) begin
				act_bank_o <= bank_select_i;
				act_row_o  <= addr_i;
			end
		end
	end

	// ==========================================================
	// read requests toward the core
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rd_req_o  <= 1'b0;
			rd_bank_o <= '0;
			rd_col_o  <= '0;
		end else if (is_rd) begin
			rd_req_o  <= 1'b1;
			rd_bank_o <= bank_select_i;
			rd_col_o  <= addr_i[COL_W-1:0];
		end else if (beat_extra & ~burst_write_reg) begin
			rd_req_o  <= 1'b1;
			rd_bank_o <= burst_bank_reg;
			rd_col_o  <= burst_col_reg;
		end else begin
			rd_req_o <= 1'b0;
		end
	end

	// ==========================================================
	// read data out; mask pipeline gives the fixed float latency
	logic [BYTES-1:0] mask_pipe_reg [DQM_READ_LATENCY];

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < DQM_READ_LATENCY; i++) begin
				mask_pipe_reg[i] <= '0;
			end
		end else begin
			mask_pipe_reg[0] <= mask_now;
			for (int i = 1; i < DQM_READ_LATENCY; i++) begin
				mask_pipe_reg[i] <= mask_pipe_reg[i-1];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			data_lines_o <= '0;
		end else if (rd_data_valid_i) begin
			data_lines_o <= rd_data_i;
		end
	end

	genvar g;
	generate
		for (g = 0; g < BYTES; g++) begin : g_oe
			always_ff @(posedge clk_i) begin
				if (reset_i) begin
					data_lines_oe_o[g] <= 1'b0;
				end else begin
					data_lines_oe_o[g] <= rd_data_valid_i & ~mask_pipe_reg[DQM_READ_LATENCY-1][g];
				end
			end
		end
	endgenerate

	// ==========================================================
	// write beats into the queue; fully masked beats are not queued
	logic              wr_beat;
	logic [BANK_W-1:0] wr_beat_bank;
	logic [COL_W-1:0]  wr_beat_col;
	logic [BYTES-1:0]  wr_beat_en;
	logic [WQ_W-1:0]   wq_out;

	assign wr_beat      = is_wr | (beat_extra & burst_write_reg);
	assign wr_beat_bank = is_wr ? bank_select_i : burst_bank_reg;
	assign wr_beat_col  = is_wr ? addr_i[COL_W-1:0] : burst_col_reg;
	assign wr_beat_en   = ~mask_now;

	// a full queue drops beats; the controller must watch wr_queue_ready_o
	write_queue #(
		.WIDTH       (WQ_W),
		.DEPTH       (QUEUE_DEPTH)
	) u_queue (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.in_valid_i  (wr_beat & (|wr_beat_en)),
		.in_ready_o  (wr_queue_ready_o),
		.in_data_i   ({wr_beat_bank, wr_beat_col, wr_beat_en, data_lines_i}),
		.out_valid_o (wr_valid_o),
		.out_ready_i (wr_ready_i),
		.out_data_o  (wq_out)
	);

	assign wr_bank_o    = wq_out[WQ_W-1 -: BANK_W];
	assign wr_col_o     = wq_out[DATA_W+BYTES +: COL_W];
	assign wr_byte_en_o = wq_out[DATA_W +: BYTES];
	assign wr_data_o    = wq_out[DATA_W-1:0];
endmodule
`default_nettype wire

// ### verilog/sdram_front_pkg.sv
/*
 * Shared constants and types for the synchronous DRAM command front end:
 * pin widths, command encodings, power states and the write queue layout.
 * Assumes one system clock shared with the external memory controller.
 */
`default_nettype none
package sdram_front_pkg;

	// ==========================================================
	// pin widths
	localparam int ROW_W  = 13;
	localparam int COL_W  = 9;
	localparam int BANK_W = 2;
	localparam int BANKS  = 4;
	localparam int DATA_W = 16;
	localparam int BYTES  = 2;

	// ==========================================================
	// address bit meanings
	localparam int PRECHARGE_SELECT_BIT = 10;
	localparam logic [COL_W-1:0] COL_STEP    = 9'h001;
	localparam logic [ROW_W-1:0] MODE_RESET  = 13'h0000;

	// ==========================================================
	// data mask timing
	localparam int DQM_READ_LATENCY = 2;

	// ==========================================================
	// burst bookkeeping
	localparam int BURST_CNT_W   = 4;
	localparam int BURST_LEN_DEF = 4;
	localparam logic [BURST_CNT_W-1:0] BURST_LAST = 4'h1;
	localparam logic [BURST_CNT_W-1:0] BURST_NONE = 4'h0;

	// ==========================================================
	// write queue
	localparam int WQ_W     = BANK_W + COL_W + BYTES + DATA_W;
	localparam int WQ_DEPTH = 32;

	// ==========================================================
	// controller-side delays in clock cycles, for reference only
	localparam int ACT_TO_ACCESS_DELAY    = 3;
	localparam int ROW_CYCLE_TIME         = 10;
	localparam int BANK_TO_BANK_ACT_DELAY = 2;
	localparam int ROW_ACTIVE_TIME        = 4000;
	localparam int MODE_SET_RECOVERY      = 2;

	// ==========================================================
	// command code is {row strobe, column strobe, write enable}, active low
	typedef enum logic [2:0] {
		CMD_MODE_SET   = 3'h0,
		CMD_REFRESH    = 3'h1,
		CMD_PRECHARGE  = 3'h2,
		CMD_ACTIVATE   = 3'h3,
		CMD_WRITE      = 3'h4,
		CMD_READ       = 3'h5,
		CMD_BURST_STOP = 3'h6,
		CMD_NOP        = 3'h7
	} cmd_e;

	typedef enum logic [1:0] {
		PWR_ACTIVE       = 2'h0,
		PWR_DOWN         = 2'h1,
		PWR_SUSPEND      = 2'h2,
		PWR_SELF_REFRESH = 2'h3
	} pwr_e;

endpackage
`default_nettype wire

// ### verilog/write_queue.sv
/*
 * Synchronous FIFO carrying write beats from the pins to the array core.
 * Assumes the filling side looks at in_ready_o before pushing.
 */
`default_nettype none
`timescale 1ns/1ps
module write_queue #(
	parameter int WIDTH = 29,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);
	localparam logic [PTR_W:0] ZERO_CNT = '0;
	localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
	localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [PTR_W:0]   count_reg;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count_reg != FULL_CNT);
	assign out_valid_o = (count_reg != ZERO_CNT);
	assign out_data_o  = mem_reg[rd_ptr_reg];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// ==========================================================
	// storage and pointers
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + PTR_ONE;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + PTR_ONE;
			end
			if (push & ~pop) begin
				count_reg <= count_reg + (PTR_W+1)'(1);
			end else if (pop & ~push) begin
				count_reg <= count_reg - (PTR_W+1)'(1);
			end
		end
	end
endmodule
`default_nettype wire
